// ===== core/buck_system_control_reg.sv
// Serial slave, control register and switching gate of the step-down converter.
// Assumes pins arrive asynchronously and an open-drain data line resolved outside.
`timescale 1ns/10ps
`default_nettype none
module buck_system_control_reg
   import buck_ctl_pkg::*;
#(
   parameter logic [6:0] DEVICE_ADDR = 7'h60,
   parameter logic [7:0][15:0] SLEW_STEP_CYCLES = SLEW_STEP_DEFAULT,
   parameter int HICCUP_CYCLES = HICCUP_OFF_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial pins
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Enable pin and fault detectors
   input wire logic enable_pin,
   input wire logic ovp_det,
   input wire logic ocp_det,
   input wire logic uvp_det,
   // Power stage controls
   output logic high_side_switch,
   output logic low_side_switch,
   output logic forced_pwm,
   output logic [6:0] reference_select,
   output logic latched_off,
   output logic hiccup_active
);

   ctl_state_s r_reg;
   ctl_state_s r_next;
   logic scl_s;
   logic sda_s;
   logic en_s;
   logic ovp_s;
   logic ocp_s;
   logic uvp_s;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic wr_stb;
   logic step_tick;
   logic [7:0] rd_byte;
   logic [7:0] ptr_inc;
   logic [7:0] rd_next;
   logic [15:0] step_len;

   // Synchronised pin views and edges
   assign scl_s = r_reg.sync2[0];
   assign sda_s = r_reg.sync2[1];
   assign en_s = r_reg.sync2[2];
   assign uvp_s = r_reg.sync2[3];
   assign ocp_s = r_reg.sync2[4];
   assign ovp_s = r_reg.sync2[5];
   assign scl_rise = scl_s & ~r_reg.scl_q;
   assign scl_fall = ~scl_s & r_reg.scl_q;
   assign start_cond = scl_s & r_reg.scl_q & r_reg.sda_q & ~sda_s;
   assign stop_cond = scl_s & r_reg.scl_q & ~r_reg.sda_q & sda_s;
   assign ptr_inc = r_reg.ptr + 8'h01;
   assign step_len = SLEW_STEP_CYCLES[r_reg.ctl[CTL_SLEW_MSB:CTL_SLEW_LSB]];

   // Read data for the current and the following pointer
   function automatic logic [7:0] reg_view(input logic [7:0] a, input ctl_state_s s);
      if (a == REF_OFFSET)
      begin
         return {REF_RESERVED_VALUE, s.target};
      end
      else if (a == CTL_OFFSET)
      begin
         return s.ctl;
      end
      return UNMAPPED_READ;
   endfunction

   assign rd_byte = reg_view(r_reg.ptr, r_reg);
   assign rd_next = reg_view(ptr_inc, r_reg);

   // Next-state logic for the whole block
   always_comb
   begin
      r_next = r_reg;
      wr_stb = 1'b0;
      step_tick = 1'b0;
      r_next.sync1 = {ovp_det, ocp_det, uvp_det, enable_pin, sda_in, scl};
      r_next.sync2 = r_reg.sync1;
      r_next.scl_q = scl_s;
      r_next.sda_q = sda_s;
      if (!en_s)
      begin
         // Pin low: converter off, serial idle, latch cleared
         r_next = STATE_RESET;
         r_next.sync1 = {ovp_det, ocp_det, uvp_det, enable_pin, sda_in, scl};
         r_next.sync2 = r_reg.sync1;
         r_next.scl_q = scl_s;
         r_next.sda_q = sda_s;
      end
      else
      begin
         // Serial engine
         if (start_cond)
         begin
            r_next.st = ST_ADDR;
            r_next.bitcnt = 4'h0;
            r_next.sda_oe = 1'b0;
         end
         else if (stop_cond)
         begin
            r_next.st = ST_IDLE;
            r_next.sda_oe = 1'b0;
         end
         else
         begin
            case (r_reg.st)
               ST_ADDR, ST_REG, ST_WDATA:
               begin
                  if (scl_rise)
                  begin
                     r_next.shreg = {r_reg.shreg[6:0], sda_s};
                     r_next.bitcnt = r_reg.bitcnt + 4'h1;
                  end
                  else if (scl_fall && r_reg.bitcnt == BITS_PER_BYTE)
                  begin
                     r_next.bitcnt = 4'h0;
                     r_next.sda_oe = 1'b1;
                     if (r_reg.st == ST_ADDR)
                     begin
                        r_next.rw = r_reg.shreg[0];
                        r_next.st = ST_ADDR_ACK;
                        if (r_reg.shreg[7:1] != DEVICE_ADDR)
                        begin
                           r_next.st = ST_IDLE;
                           r_next.sda_oe = 1'b0;
                        end
                     end
                     else if (r_reg.st == ST_REG)
                     begin
                        r_next.ptr = r_reg.shreg;
                        r_next.st = ST_REG_ACK;
                     end
                     else
                     begin
                        wr_stb = 1'b1;
                        r_next.st = ST_WDATA_ACK;
                     end
                  end
               end
               ST_ADDR_ACK:
               begin
                  if (scl_fall)
                  begin
                     r_next.bitcnt = 4'h0;
                     r_next.sda_oe = 1'b0;
                     r_next.st = ST_REG;
                     if (r_reg.rw)
                     begin
                        r_next.shreg = rd_byte;
                        r_next.sda_oe = ~rd_byte[7];
                        r_next.bitcnt = 4'h1;
                        r_next.st = ST_TX;
                     end
                  end
               end
               ST_REG_ACK, ST_WDATA_ACK:
               begin
                  if (scl_fall)
                  begin
                     r_next.sda_oe = 1'b0;
                     r_next.st = ST_WDATA;
                     if (r_reg.st == ST_WDATA_ACK)
                     begin
                        r_next.ptr = ptr_inc;
                     end
                  end
               end
               ST_TX:
               begin
                  if (scl_fall)
                  begin
                     if (r_reg.bitcnt == BITS_PER_BYTE)
                     begin
                        r_next.sda_oe = 1'b0;
                        r_next.st = ST_MACK;
                     end
                     else
                     begin
                        r_next.shreg = {r_reg.shreg[6:0], 1'b0};
                        r_next.sda_oe = ~r_reg.shreg[6];
                        r_next.bitcnt = r_reg.bitcnt + 4'h1;
                     end
                  end
               end
               ST_MACK:
               begin
                  if (scl_rise && sda_s)
                  begin
                     r_next.st = ST_IDLE;
                  end
                  else if (scl_fall)
                  begin
                     r_next.ptr = ptr_inc;
                     r_next.shreg = rd_next;
                     r_next.sda_oe = ~rd_next[7];
                     r_next.bitcnt = 4'h1;
                     r_next.st = ST_TX;
                  end
               end
               default:
               begin
                  r_next.sda_oe = 1'b0;
               end
            endcase
         end

         // Linear reference ramp; grant clears when the target is reached
         if (r_reg.scaling)
         begin
            if (r_reg.ref_now == r_reg.target)
            begin
               r_next.scaling = 1'b0;
               r_next.ctl[CTL_GRANT_BIT] = 1'b0;
               r_next.slew_cnt = 16'h0000;
            end
            else if (r_reg.slew_cnt >= step_len - 16'h0001)
            begin
               step_tick = 1'b1;
               r_next.slew_cnt = 16'h0000;
               if (r_reg.ref_now < r_reg.target)
               begin
                  r_next.ref_now = r_reg.ref_now + 7'h01;
               end
               else
               begin
                  r_next.ref_now = r_reg.ref_now - 7'h01;
               end
            end
            else
            begin
               r_next.slew_cnt = r_reg.slew_cnt + 16'h0001;
            end
         end

         // Register writes after the hardware clear, so a set wins
         if (wr_stb && r_reg.ptr == REF_OFFSET && r_reg.ctl[CTL_GRANT_BIT])
         begin
            r_next.target = r_reg.shreg[6:0];
            r_next.scaling = 1'b1;
         end
         else if (wr_stb && r_reg.ptr == CTL_OFFSET)
         begin
            r_next.ctl = r_reg.shreg;
         end

         // Fault handling
         if (r_reg.hiccup)
         begin
            r_next.hic_cnt = r_reg.hic_cnt + 24'h000001;
            if (r_reg.hic_cnt >= 24'(HICCUP_CYCLES - 1))
            begin
               r_next.hiccup = 1'b0;
               r_next.hic_cnt = 24'h000000;
            end
         end
         if (!r_reg.latched)
         begin
            if (ovp_s && !r_reg.ctl[CTL_RETRY_BIT])
            begin
               r_next.latched = 1'b1;
            end
            if (ocp_s && uvp_s)
            begin
               if (r_reg.ctl[CTL_HICCUP_BIT])
               begin
                  r_next.hiccup = 1'b1;
                  r_next.hic_cnt = 24'h000000;
               end
               else
               begin
                  r_next.latched = 1'b1;
               end
            end
         end

         // Switch gate and light-load mode
         r_next.sw_gate = r_reg.ctl[CTL_SW_EN_BIT] & ~ovp_s & ~r_reg.latched
            & ~r_reg.hiccup;
         r_next.pwm_forced = r_reg.ctl[CTL_GRANT_BIT] | r_reg.ctl[CTL_MODE_BIT];
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         r_reg <= STATE_RESET;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // Outputs
   assign sda_out = 1'b0;
   assign sda_oe = r_reg.sda_oe;
   assign high_side_switch = r_reg.sw_gate;
   assign low_side_switch = r_reg.sw_gate;
   assign forced_pwm = r_reg.pwm_forced;
   assign reference_select = r_reg.ref_now;
   assign latched_off = r_reg.latched;
   assign hiccup_active = r_reg.hiccup;

   // Checks
   property p_sw_bit_off;
      @(posedge clk) disable iff (rst)
      !r_reg.ctl[CTL_SW_EN_BIT] |=> !high_side_switch && !low_side_switch;
   endproperty
   a_sw_bit_off: assert property (p_sw_bit_off) else $error("switching with enable bit 0");

   property p_pin_off;
      @(posedge clk) disable iff (rst)
      !en_s |=> !high_side_switch && !sda_oe && r_reg.st == ST_IDLE;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("active with enable pin low");

   property p_reset_values;
      @(posedge clk) $past(rst) && !rst |-> r_reg.ctl == CTL_RESET;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("control reset value");

   property p_ref_locked;
      @(posedge clk) disable iff (rst)
      wr_stb && r_reg.ptr == REF_OFFSET && !r_reg.ctl[CTL_GRANT_BIT]
         |=> $stable(r_reg.target);
   endproperty
   a_ref_locked: assert property (p_ref_locked) else $error("reference written without grant");

   property p_grant_clear;
      @(posedge clk) disable iff (rst)
      r_reg.scaling && r_reg.ref_now == r_reg.target && !wr_stb && en_s
         |=> !r_reg.ctl[CTL_GRANT_BIT] && !r_reg.scaling;
   endproperty
   a_grant_clear: assert property (p_grant_clear) else $error("grant not cleared");

   property p_forced_pwm;
      @(posedge clk) disable iff (rst)
      en_s && r_reg.ctl[CTL_GRANT_BIT] ##1 en_s |-> forced_pwm;
   endproperty
   a_forced_pwm: assert property (p_forced_pwm) else $error("no forced PWM during scaling");

   property p_ramp_step;
      @(posedge clk) disable iff (rst)
      en_s && $changed(r_reg.ref_now) |-> $past(step_tick);
   endproperty
   a_ramp_step: assert property (p_ramp_step) else $error("reference jumped");

   property p_ovp_latch;
      @(posedge clk) disable iff (rst)
      en_s && ovp_s && !r_reg.ctl[CTL_RETRY_BIT] ##1 en_s |-> latched_off ##1 !high_side_switch;
   endproperty
   a_ovp_latch: assert property (p_ovp_latch) else $error("no latch on over-voltage");

   property p_hiccup;
      @(posedge clk) disable iff (rst)
      en_s && !r_reg.latched && ocp_s && uvp_s && r_reg.ctl[CTL_HICCUP_BIT] ##1 en_s
         |-> hiccup_active;
   endproperty
   a_hiccup: assert property (p_hiccup) else $error("no hiccup entry");

   property p_ocp_latch;
      @(posedge clk) disable iff (rst)
      en_s && ocp_s && uvp_s && !r_reg.ctl[CTL_HICCUP_BIT] ##1 en_s |-> latched_off;
   endproperty
   a_ocp_latch: assert property (p_ocp_latch) else $error("no latch on over-current");

   property p_light_load;
      @(posedge clk) disable iff (rst)
      en_s && !r_reg.ctl[CTL_GRANT_BIT] && !r_reg.ctl[CTL_MODE_BIT] ##1 en_s |-> !forced_pwm;
   endproperty
   a_light_load: assert property (p_light_load) else $error("PWM forced in auto mode");

   property p_byte_ack;
      @(posedge clk) disable iff (rst)
      r_reg.st == ST_REG_ACK || r_reg.st == ST_WDATA_ACK |-> sda_oe;
   endproperty
   a_byte_ack: assert property (p_byte_ack) else $error("byte not acknowledged");

endmodule
`default_nettype wire

// ===== core/buck_ctl_pkg.sv
// Constants, state types and register layout for the converter control block.
// Assumes a 10 MHz system clock and a two-wire serial host outside the device.
// Contract
// - With enable pin high, software enable bit 0 stops both switches, 1 resumes.
// - Enable pin low holds converter off and shuts the serial interface down.
// - Software enable bit resets to 1 so converter runs once enable pin rises.
// - Reference writes take effect only while the grant bit (bit 6) is 1.
// - Grant bit resets to 0 and clears itself when the reference ramp ends.
// - Grant bit 1 forces PWM; afterwards the mode bit choice returns.
// - Slew field bits 5..3, reset 100, picks rate of linear ramp to new voltage.
// - Over-voltage retry bit 1 (reset 1): resume automatically once over-voltage clears.
// - Over-voltage retry bit 0: latch off until enable pin or supply cycles.
// - Hiccup bit 1 (reset 1): over-current plus under-voltage starts hiccup.
// - Hiccup bit 0: over-current plus under-voltage latches the converter off.
// - Mode bit 0 (reset 0): auto PFM/PWM at light load; 1: forced PWM.
// - Update is start, device address, register address, data; each byte acknowledged.
// - Lower seven bits of register 0 set reference 0.6 V to 1.108 V linearly.
package buck_ctl_pkg;

   // Clock and timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int SLEW_BASE_NS = 1000;
   localparam int SLEW_BASE_CYCLES = SLEW_BASE_NS / CLK_PERIOD_NS;
   localparam int HICCUP_OFF_US = 1000;
   localparam int HICCUP_OFF_CYCLES = HICCUP_OFF_US * 1000 / CLK_PERIOD_NS;

   // Default cycles per reference step, code 7 first, code 0 slowest
   localparam logic [7:0][15:0] SLEW_STEP_DEFAULT = {
      16'(SLEW_BASE_CYCLES), 16'(SLEW_BASE_CYCLES * 2),
      16'(SLEW_BASE_CYCLES * 4), 16'(SLEW_BASE_CYCLES * 8),
      16'(SLEW_BASE_CYCLES * 16), 16'(SLEW_BASE_CYCLES * 32),
      16'(SLEW_BASE_CYCLES * 64), 16'(SLEW_BASE_CYCLES * 128)};

   // Register offsets
   localparam logic [7:0] REF_OFFSET = 8'h00;
   localparam logic [7:0] CTL_OFFSET = 8'h01;

   // Control register fields
   localparam int CTL_SW_EN_BIT = 7;
   localparam int CTL_GRANT_BIT = 6;
   localparam int CTL_SLEW_MSB = 5;
   localparam int CTL_SLEW_LSB = 3;
   localparam int CTL_RETRY_BIT = 2;
   localparam int CTL_HICCUP_BIT = 1;
   localparam int CTL_MODE_BIT = 0;

   // Values after reset, fixed read values and bits per byte
   localparam logic [7:0] CTL_RESET = 8'hA6;
   localparam logic [6:0] REF_RESET = 7'h1E;
   localparam logic REF_RESERVED_VALUE = 1'b1;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Serial engine states
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_TX, ST_MACK
   } serial_state_e;

   // Whole block state
   typedef struct packed {
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic scl_q;
      logic sda_q;
      serial_state_e st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic rw;
      logic [7:0] ptr;
      logic sda_oe;
      logic [7:0] ctl;
      logic [6:0] target;
      logic [6:0] ref_now;
      logic scaling;
      logic [15:0] slew_cnt;
      logic latched;
      logic hiccup;
      logic [23:0] hic_cnt;
      logic sw_gate;
      logic pwm_forced;
   } ctl_state_s;

   localparam ctl_state_s STATE_RESET = '{st: ST_IDLE, ctl: CTL_RESET,
      target: REF_RESET, ref_now: REF_RESET, default: '0};

endpackage

// ===== tb/i2c_host_model.sv
// Two-wire host model writing and reading device registers.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h60
)
(
   // Alignment clock
   input wire logic clk,
   // Bus lines
   output logic scl,
   output logic sda_low,
   input wire logic sda_line
);
   logic [6:0] target_addr = DEV_ADDR;
   // Idle bus, clock stands high between frames
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Bit out, data set while clock low
   task automatic put_bit(input logic b);
      #100 sda_low = ~b;
      #300 scl = 1'b1;
      #400 scl = 1'b0;
   endtask
   // Bit in, line released, sampled mid-high
   task automatic get_bit(output logic b);
      #100 sda_low = 1'b0;
      #300 scl = 1'b1;
      #200 b = sda_line;
      #200 scl = 1'b0;
   endtask
   // Start or repeated start
   task automatic start_cond();
      #100 sda_low = 1'b0;
      #300 scl = 1'b1;
      #400 sda_low = 1'b1;
      #400 scl = 1'b0;
   endtask
   task automatic stop_cond();
      #100 sda_low = 1'b1;
      #300 scl = 1'b1;
      #400 sda_low = 1'b0;
      #400;
   endtask
   // Byte out MSB first, acknowledge folded into ok
   task automatic put_byte(input logic [7:0] d, inout logic ok);
      logic a;
      for (int i = 7; i >= 0; i--)
         put_bit(d[i]);
      get_bit(a);
      ok = ok & ~a;
   endtask
   // Address, offset, data in one frame
   task automatic write_reg(input logic [7:0] off, input logic [7:0] d, output logic ok);
      ok = 1'b1;
      @(posedge clk);
      #10 start_cond();
      put_byte({target_addr, 1'b0}, ok);
      put_byte(off, ok);
      put_byte(d, ok);
      stop_cond();
   endtask
   // Offset, repeated start, one byte back
   task automatic read_reg(input logic [7:0] off, output logic [7:0] d, output logic ok);
      logic b;
      ok = 1'b1;
      @(posedge clk);
      #10 start_cond();
      put_byte({target_addr, 1'b0}, ok);
      put_byte(off, ok);
      start_cond();
      put_byte({target_addr, 1'b1}, ok);
      for (int i = 7; i >= 0; i--)
      begin
         get_bit(b);
         d[i] = b;
      end
      put_bit(1'b1); // Nack ends the read
      stop_cond();
   endtask
endmodule
`default_nettype wire

// ===== tb/tb_buck_system_control_reg.sv
// Self-checking bench for the converter control block.
// Assumes the host model drives the serial pins at an 800 ns bit rate.
`timescale 1ns/10ps
`default_nettype none
module tb_buck_system_control_reg;
   import buck_ctl_pkg::*;
   localparam logic [7:0][15:0] STEPS = {16'h0004, 16'h0008, 16'h000C, 16'h0028,
      16'h0010, 16'h0014, 16'h0018, 16'h001C};
   logic clk, rst, enable_pin, ovp_det, ocp_det, uvp_det, ok;
   logic sda_out, sda_oe, hs, ls, forced_pwm, latched_off, hiccup_active;
   logic [6:0] reference_select;
   logic [7:0] rd;
   logic [9:0] rows [8] = '{{8'h87, 2'b11}, {8'h0E, 2'b00}, {8'h93, 2'b11},
      {8'h19, 2'b10}, {8'hA6, 2'b01}, {8'h2D, 2'b10}, {8'hB0, 2'b01}, {8'h3F, 2'b10}};
   wire scl, host_low;
   wire sda_line = (sda_oe ? sda_out : 1'b1) & ~host_low;
   int fails = 0;
   int comparisons = 0;
   int n;
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   buck_system_control_reg #(.SLEW_STEP_CYCLES(STEPS), .HICCUP_CYCLES(20))
      buck_system_control_reg_i (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin), .ovp_det(ovp_det),
      .ocp_det(ocp_det), .uvp_det(uvp_det), .high_side_switch(hs), .low_side_switch(ls),
      .forced_pwm(forced_pwm), .reference_select(reference_select),
      .latched_off(latched_off), .hiccup_active(hiccup_active));
   i2c_host_model #(.DEV_ADDR(7'h60)) i2c_host_model_i (.clk(clk), .scl(scl),
      .sda_low(host_low), .sda_line(sda_line));
   // Helpers
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #10;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cycle_en();
      enable_pin = 1'b0;
      tick(6);
      enable_pin = 1'b1;
      tick(6);
   endtask
   task automatic wr_ctl(input logic [7:0] d);
      i2c_host_model_i.write_reg(CTL_OFFSET, d, ok);
      tick(4);
   endtask
   task automatic summarize();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #5000000;
      fails++;
      summarize();
   end
   // Main sequence
   initial
   begin
      {ovp_det, ocp_det, uvp_det} = 3'b000;
      enable_pin = 1'b1;
      rst = 1'b1;
      tick(6);
      rst = 1'b0;
      tick(4);
      foreach (rows[i])
      begin
         wr_ctl(rows[i][9:2]);
         chk("ctl ack", 8'h01, ok);
         i2c_host_model_i.read_reg(CTL_OFFSET, rd, ok);
         chk("ctl", rows[i][9:2], rd);
         chk("pwm", rows[i][1], forced_pwm);
         chk("switches", {2{rows[i][0]}}, {hs, ls});
      end
      // Second reset mid-run, then reset values
      rst = 1'b1;
      tick(6);
      rst = 1'b0;
      tick(4);
      i2c_host_model_i.read_reg(CTL_OFFSET, rd, ok);
      chk("ctl reset", 8'hA6, rd);
      i2c_host_model_i.read_reg(REF_OFFSET, rd, ok);
      chk("ref reset", 8'h9E, rd);
      chk("sw reset", 8'h03, {hs, ls});
      // Reference write without grant is dropped
      i2c_host_model_i.write_reg(REF_OFFSET, 8'h22, ok);
      tick(60);
      chk("ref locked", 8'h1E, reference_select);
      i2c_host_model_i.read_reg(REF_OFFSET, rd, ok);
      chk("ref reg locked", 8'h9E, rd);
      // Scaling with slew code 4
      wr_ctl(8'hE6);
      chk("pwm grant", 8'h01, forced_pwm);
      i2c_host_model_i.write_reg(REF_OFFSET, 8'h22, ok);
      n = 0;
      while (reference_select === 7'h1E && n < 200)
      begin
         tick(1);
         n++;
      end
      chk("first step", 8'h1F, reference_select);
      n = 0;
      while (reference_select !== 7'h22 && n < 400)
      begin
         tick(1);
         n++;
      end
      chk("ramp cycles", 8'h78, n[7:0]);
      rd = 8'hFF;
      n = 0;
      while (rd[6] !== 1'b0 && n < 8)
      begin
         i2c_host_model_i.read_reg(CTL_OFFSET, rd, ok);
         n++;
      end
      chk("grant clear", 8'hA6, rd);
      chk("pwm back", 8'h00, forced_pwm);
      i2c_host_model_i.write_reg(REF_OFFSET, 8'h10, ok);
      tick(60);
      chk("no regrant", 8'h22, reference_select);
      i2c_host_model_i.read_reg(REF_OFFSET, rd, ok);
      chk("ref reg kept", 8'hA2, rd);
      // Foreign address and enable pin low
      i2c_host_model_i.target_addr = 7'h61;
      wr_ctl(8'h00);
      chk("foreign ack", 8'h00, ok);
      i2c_host_model_i.target_addr = 7'h60;
      enable_pin = 1'b0;
      tick(6);
      chk("pin off", 8'h00, {hs, ls});
      wr_ctl(8'h80);
      chk("pin off ack", 8'h00, ok);
      enable_pin = 1'b1;
      tick(6);
      chk("pin on", 8'h03, {hs, ls});
      // Over-voltage with retry then latch
      ovp_det = 1'b1;
      tick(6);
      chk("ovp gate", 8'h00, hs);
      ovp_det = 1'b0;
      tick(6);
      chk("ovp retry", 8'h01, hs);
      wr_ctl(8'h80);
      ovp_det = 1'b1;
      tick(6);
      ovp_det = 1'b0;
      tick(6);
      chk("ovp latch", 8'h01, latched_off);
      chk("ovp off", 8'h00, hs);
      cycle_en();
      chk("latch cleared", 8'h01, hs);
      chk("latch flag cleared", 8'h00, latched_off);
      // Over-current with hiccup then latch; one-cycle fault, off time counts after it
      {ocp_det, uvp_det} = 2'b11;
      tick(1);
      {ocp_det, uvp_det} = 2'b00;
      n = 0;
      while (hiccup_active !== 1'b1 && n < 10)
      begin
         tick(1);
         n++;
      end
      n = 0;
      while (hiccup_active === 1'b1 && n < 100)
      begin
         tick(1);
         n++;
      end
      chk("hiccup len", 8'h14, n[7:0]);
      tick(3);
      chk("hiccup retry", 8'h01, hs);
      wr_ctl(8'h84);
      {ocp_det, uvp_det} = 2'b11;
      tick(6);
      {ocp_det, uvp_det} = 2'b00;
      tick(30);
      chk("ocp latch", 8'h01, latched_off);
      chk("ocp off", 8'h00, hs);
      cycle_en();
      chk("ocp latch cleared", 8'h00, latched_off);
      summarize();
   end
endmodule
`default_nettype wire
